// file: bench/padc_props.sv
`timescale 1ns/1ns
// ==================================================
// Link checker beside the interface
module padc_props
(
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    input  wire logic        conv_clk,
    input  wire logic        conv_clk_fall,
    input  wire logic        conv_clk_rise,
    input  wire logic        cal_hi,
    input  wire logic        read_n,
    input  wire logic        power_down_low,
    input  wire logic [15:0] data_o,
    input  wire logic        data_oe,
    input  wire logic        eoc_n,
    input  wire logic [15:0] data_bus
);
    logic [8:0] fresh_r;
    // Cycles since the last power down or calibration request; saturates so it never wraps
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            fresh_r <= 9'h000;
        else if (!power_down_low || cal_hi)
            fresh_r <= 9'h000;
        else if (fresh_r != 9'h1FF)
            fresh_r <= fresh_r + 9'h001;
    end
    // ==================================================
    // Properties
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    sequence quiet_gap_s; !conv_clk_fall [*8]; endsequence
    sequence next_fall_s; quiet_gap_s ##12 conv_clk_fall; endsequence
    oe_read_a: assert property (data_oe |-> !read_n)
        else $error("data driven while read is high");
    oe_power_a: assert property (!power_down_low |=> !data_oe)
        else $error("data driven in power down");
    bus_drive_a: assert property (data_oe |-> data_bus == data_o)
        else $error("bus differs from driven word");
    eoc_idle_a: assert property (!power_down_low |-> ##[1:2] eoc_n)
        else $error("valid flag kept in power down");
    // The flag may lag a new calibration or power down by one cycle
    eoc_fill_a: assert property (!eoc_n && !$past(cal_hi) && $past(power_down_low)
        |-> fresh_r >= 9'h0F0)
        else $error("valid flag before pipeline refilled");
    data_hold_a: assert property (!$stable(data_o) |-> $past(conv_clk_fall))
        else $error("word changed off the output edge");
    sample_low_a: assert property (conv_clk_fall |=> !conv_clk)
        else $error("sample clock not low after sampling mark");
    output_high_a: assert property (conv_clk_rise |=> conv_clk)
        else $error("sample clock not high after rising mark");
    fall_period_a: assert property (conv_clk_fall |=> next_fall_s)
        else $error("sample period is not twenty cycles");
    edge_apart_a: assert property (conv_clk_rise |-> !conv_clk_fall)
        else $error("rise and fall marks coincide");
endmodule

// file: bench/pipelined_adc_output_port_bench.sv
`timescale 1ns/1ns
module pipelined_adc_output_port_bench;
    logic               i_clk;
    logic               i_rst_n;
    logic signed [16:0] i_analog;
    logic               i_reset_req;
    logic               i_cal_req;
    logic               o_calibrating;
    logic               i_read_en;
    logic               i_power_on;
    logic               o_idle;
    logic [15:0]        o_word;
    logic               o_word_valid;
    int                 error_cnt;
    int                 n_checks;
    // ==================================================
    // Both ends joined by the interface
    padc_if padc_if_inst ();
    padc_device padc_device_inst (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_analog(i_analog),
        .i_clk_fall_sel(1'b0), .link(padc_if_inst.device), .o_idle(o_idle),
        .o_calibrating(o_calibrating));
    // A full calibration is too long to run; the bench ends it with a reset
    padc_capture padc_capture_inst (.i_clk(i_clk), .i_rst_n(i_rst_n),
        .i_reset_req(i_reset_req), .i_cal_req(i_cal_req), .i_read_en(i_read_en),
        .i_power_on(i_power_on), .link(padc_if_inst.capture), .o_word(o_word),
        .o_word_valid(o_word_valid), .o_mux_step());
    padc_props padc_props_inst (.i_clk(i_clk), .i_rst_n(i_rst_n),
        .conv_clk(padc_if_inst.conv_clk),
        .conv_clk_fall(padc_if_inst.conv_clk_fall), .conv_clk_rise(padc_if_inst.conv_clk_rise),
        .cal_hi(padc_if_inst.cal_hi), .read_n(padc_if_inst.read_n),
        .power_down_low(padc_if_inst.power_down_low), .data_o(padc_if_inst.data_o),
        .data_oe(padc_if_inst.data_oe), .eoc_n(padc_if_inst.eoc_n),
        .data_bus(padc_if_inst.data_bus));
    // ==================================================
    // Shared tasks
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("unexpected at %0t: got %h wanted %h", $time, got, exp);
        end
    endtask
    // Bounded wait for a captured word
    task automatic wait_word();
        for (int i = 0; i < 60 && o_word_valid !== 1'b1; i++)
            @(negedge i_clk);
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // ==================================================
    // Scenarios
    task automatic t_codes();
        logic signed [16:0] vin [5] = '{17'h0C350, 17'h163C0, 17'h00000, 17'h1FFFB, 17'h004D2};
        logic [15:0]        exp [5] = '{16'h7FFF, 16'h8000, 16'h0000, 16'hFFFB, 16'h04D2};
        for (int k = 0; k < 5; k++)
        begin
            @(posedge i_clk) i_analog <= vin[k];
            repeat (320) @(negedge i_clk);
            wait_word();
            chk(o_word, exp[k]);
            chk(padc_if_inst.data_bus, exp[k]);
        end
    endtask
    // New value sampled at a known fall must land 13 samples later
    task automatic t_latency();
        int n;
        @(posedge i_clk) i_analog <= 17'h00100;
        repeat (320) @(negedge i_clk);
        for (n = 0; n < 40 && padc_if_inst.conv_clk_fall !== 1'b1; n++)
            @(negedge i_clk);
        // Next fall, one period on, takes the new value; seen a half cycle after it lands
        @(posedge i_clk) i_analog <= 17'h00200;
        for (n = 0; n < 400 && padc_if_inst.data_o !== 16'h0200; n++)
            @(negedge i_clk);
        chk(16'(n), 16'(padc_pkg::SAMPLE_DIV * (padc_pkg::PIPE_DEPTH + 1) + 1));
        wait_word();
        chk(o_word, 16'h0200);
    endtask
    // Calibration blocks valid words and runs on until a reset ends it
    task automatic t_cal();
        int seen = 0;
        @(posedge i_clk) i_cal_req <= 1'b1;
        repeat (60) @(negedge i_clk) seen += (o_word_valid === 1'b1);
        chk(16'(o_calibrating), 16'h0001);
        chk(16'(padc_if_inst.eoc_n), 16'h0001);
        chk(16'(seen), 16'h0000);
        @(posedge i_clk) i_cal_req <= 1'b0;
        repeat (200) @(negedge i_clk);
        chk(16'(o_calibrating), 16'h0001);
        @(posedge i_clk) i_reset_req <= 1'b1;
        repeat (60) @(negedge i_clk);
        chk(16'(o_calibrating), 16'h0000);
        @(posedge i_clk) i_reset_req <= 1'b0;
    endtask
    task automatic t_read();
        int seen = 0;
        @(posedge i_clk) i_read_en <= 1'b0;
        repeat (3) @(negedge i_clk);
        chk(16'(padc_if_inst.data_oe), 16'h0000);
        chk(padc_if_inst.data_bus, 16'h0000);
        repeat (60) @(negedge i_clk) seen += (o_word_valid === 1'b1);
        chk(16'(seen), 16'h0000);
        @(posedge i_clk) i_read_en <= 1'b1;
    endtask
    task automatic t_power();
        @(posedge i_clk) i_power_on <= 1'b0;
        repeat (5) @(negedge i_clk);
        chk(16'(o_idle), 16'h0001);
        chk(16'(padc_if_inst.eoc_n), 16'h0001);
        @(posedge i_clk) i_power_on <= 1'b1;
    endtask
    // Long reset, then no valid word until the pipeline refills
    task automatic t_reset();
        @(posedge i_clk) i_reset_req <= 1'b1;
        repeat (60) @(negedge i_clk);
        chk(16'(padc_if_inst.eoc_n), 16'h0001);
        @(posedge i_clk) i_reset_req <= 1'b0;
        repeat (150) @(negedge i_clk);
        chk(16'(padc_if_inst.eoc_n), 16'h0001);
        repeat (300) @(negedge i_clk);
        wait_word();
        chk(16'(o_word_valid), 16'h0001);
    endtask
    // ==================================================
    // Clock, watchdog and main sequence
    initial
    begin
        i_clk = 1'b0;
        forever #10 i_clk = ~i_clk;
    end
    initial
    begin
        repeat (20000) @(posedge i_clk);
        error_cnt++;
        final_report();
    end
    initial
    begin
        error_cnt = 0;
        n_checks = 0;
        i_rst_n = 1'b0;
        i_analog = 17'h00000;
        i_reset_req = 1'b0;
        i_cal_req = 1'b0;
        i_read_en = 1'b1;
        i_power_on = 1'b1;
        repeat (12) @(posedge i_clk);
        i_rst_n <= 1'b1;
        t_codes();
        t_latency();
        t_read();
        t_power();
        t_cal();
        t_reset();
        final_report();
    end
endmodule

// file: hw/padc_capture.sv
`timescale 1ns/1ns
module padc_capture
(
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_reset_req,
    input  wire logic        i_cal_req,
    input  wire logic        i_read_en,
    input  wire logic        i_power_on,
    padc_if.capture          link,
    output logic [15:0]      o_word,
    output logic             o_word_valid,
    output logic             o_mux_step
);
    //==========================================================
    // Sample clock divider
    //==========================================================
    logic [padc_pkg::DIV_W-1:0] div_r;
    logic                       conv_clk_r;
    logic [15:0]                word_r;
    logic                       valid_r;

    // Fixed 2.5 MHz rate keeps the device inside its legal range
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            div_r <= padc_pkg::DIV_ZERO;
        else if (div_r == padc_pkg::DIV_LAST)
            div_r <= padc_pkg::DIV_ZERO;
        else
            div_r <= div_r + 1'b1;
    end

    // High in the first half, falls at DIV_HALF
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            conv_clk_r <= 1'b0;
        else
            conv_clk_r <= (div_r == padc_pkg::DIV_LAST) || (div_r < padc_pkg::DIV_HALF);
    end

    assign link.conv_clk       = conv_clk_r;
    assign link.conv_clk_fall  = div_r == padc_pkg::DIV_HALF;
    assign link.conv_clk_rise  = div_r == padc_pkg::DIV_LAST;
    // Mux steps away from the sampling edge
    assign o_mux_step          = link.conv_clk_rise;

    //==========================================================
    // Control pins
    //==========================================================
    // Requests held by user for at least two sample clocks
    assign link.reset_hi       = i_reset_req;
    assign link.cal_hi         = i_cal_req;
    assign link.read_n         = !i_read_en;
    assign link.power_down_low = i_power_on;

    //==========================================================
    // Word capture
    //==========================================================
    // Latch on the rise, half a period after the word changes; drop invalid words
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            word_r  <= 16'h0000;
            valid_r <= 1'b0;
        end
        else if (link.conv_clk_rise)
        begin
            valid_r <= link.data_oe && !link.eoc_n && !i_reset_req && !i_cal_req;
            word_r  <= link.data_oe ? link.data_o : 16'h0000;
        end
        else
            valid_r <= 1'b0;
    end

    assign o_word       = word_r;
    assign o_word_valid = valid_r;
endmodule

// file: hw/padc_device.sv
`timescale 1ns/1ns
module padc_device
(
    input  wire logic                i_clk,
    input  wire logic                i_rst_n,
    input  wire logic signed [16:0]  i_analog,     // Differential input, 17 bits so it can overrange
    input  wire logic                i_clk_fall_sel,
    padc_if.device                   link,
    output logic                     o_idle,
    output logic                     o_calibrating
);
    //==========================================================
    // Mode control
    //==========================================================
    padc_pkg::padc_mode_t       mode_r;
    logic [padc_pkg::CAL_W-1:0] cal_cnt_r;
    logic [1:0]                 rst_cnt_r;
    logic [padc_pkg::FILL_W-1:0] fill_r;
    logic signed [15:0]         pipe_r [padc_pkg::PIPE_DEPTH];
    logic [15:0]                out_r;
    logic                       eoc_n_r;
    logic signed [15:0]         sample_nxt;

    // Reset count; a one-cycle glitch does not clear the pipeline
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            rst_cnt_r <= 2'h0;
        else if (!link.reset_hi)
            rst_cnt_r <= 2'h0;
        else if (link.conv_clk_rise && rst_cnt_r != 2'h3)
            rst_cnt_r <= rst_cnt_r + 2'h1;
    end

    // Mode sequencing: power down beats reset beats calibration
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            mode_r    <= padc_pkg::PADC_RESET;
            cal_cnt_r <= '0;
        end
        else if (!link.power_down_low)
            mode_r <= padc_pkg::PADC_IDLE;
        else if (link.reset_hi)
        begin
            if (rst_cnt_r >= 2'(padc_pkg::RESET_MIN_CY - 1))
                mode_r <= padc_pkg::PADC_RESET;
        end
        else if (link.cal_hi && mode_r != padc_pkg::PADC_CAL)
        begin
            mode_r    <= padc_pkg::PADC_CAL;
            cal_cnt_r <= '0;
        end
        else if (mode_r == padc_pkg::PADC_CAL)
        begin
            if (link.conv_clk_rise)
            begin
                if (cal_cnt_r == padc_pkg::CAL_W'(padc_pkg::CAL_CYCLES - 1))
                    mode_r <= padc_pkg::PADC_RUN;
                else
                    cal_cnt_r <= cal_cnt_r + 1'b1;
            end
        end
        else if (mode_r != padc_pkg::PADC_RUN)
            mode_r <= padc_pkg::PADC_RUN;
    end

    //==========================================================
    // Conversion pipeline
    //==========================================================
    // Saturating quantiser, two's complement
    always_comb
    begin
        if (i_analog < padc_pkg::ANALOG_MIN)
            sample_nxt = padc_pkg::CODE_NEG_FS;
        else if (i_analog > padc_pkg::ANALOG_MAX)
            sample_nxt = padc_pkg::CODE_POS_FS;
        else
            sample_nxt = i_analog[15:0];
    end

    // Sample on falling edge, shift once per sample clock
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            for (int k = 0; k < padc_pkg::PIPE_DEPTH; k++)
                pipe_r[k] <= padc_pkg::CODE_MID;
        end
        else if (link.conv_clk_fall)
        begin
            pipe_r[0] <= sample_nxt;
            for (int k = 1; k < padc_pkg::PIPE_DEPTH; k++)
                pipe_r[k] <= pipe_r[k-1];
        end
    end

    // Refill count: words only valid after thirteen fresh samples
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            fill_r <= '0;
        else if (mode_r != padc_pkg::PADC_RUN)
            fill_r <= '0;
        else if (link.conv_clk_fall && fill_r != padc_pkg::FILL_W'(padc_pkg::PIPE_DEPTH))
            fill_r <= fill_r + 1'b1;
    end

    // Output register loads on the fall thirteen samples after capture,
    // so the word is settled at the rise where the capture end latches it
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            out_r   <= padc_pkg::CODE_MID;
            eoc_n_r <= 1'b1;
        end
        else if (link.conv_clk_fall)
        begin
            out_r   <= pipe_r[padc_pkg::PIPE_DEPTH-1];
            eoc_n_r <= !(mode_r == padc_pkg::PADC_RUN
                         && fill_r == padc_pkg::FILL_W'(padc_pkg::PIPE_DEPTH));
        end
        else if (mode_r != padc_pkg::PADC_RUN)
            eoc_n_r <= 1'b1;
    end

    //==========================================================
    // Pins
    //==========================================================
    // Drivers only on while read is low; off in idle to save power
    assign link.data_o    = out_r;
    assign link.data_oe   = !link.read_n && mode_r != padc_pkg::PADC_IDLE;
    assign link.eoc_n     = eoc_n_r;
    assign o_idle         = mode_r == padc_pkg::PADC_IDLE;
    assign o_calibrating  = mode_r == padc_pkg::PADC_CAL;
    logic unused_sel;
    assign unused_sel = i_clk_fall_sel;
endmodule

// file: hw/padc_if.sv
`timescale 1ns/1ns
interface padc_if;
    logic        conv_clk;       // Sample clock, driven by capture end
    logic        conv_clk_fall;  // One-cycle pulse marking the sampling edge
    logic        conv_clk_rise;  // One-cycle pulse marking the capture edge, where the word is latched
    logic        reset_hi;       // Level reset, active high
    logic        cal_hi;         // Level calibration request, active high
    logic        read_n;         // Output enable, active low
    logic        power_down_low; // Power down, active low
    logic [15:0] data_o;         // Device data drive
    logic        data_oe;        // Device data drive enable
    logic        eoc_n;          // Valid word present, active low
    wire  [15:0] data_bus;
    // Released bus reads as its pull-down level
    assign data_bus = data_oe ? data_o : 16'h0000;
    modport device
    (
        input  conv_clk, conv_clk_fall, conv_clk_rise, reset_hi, cal_hi, read_n,
               power_down_low,
        output data_o, data_oe, eoc_n
    );
    modport capture
    (
        output conv_clk, conv_clk_fall, conv_clk_rise, reset_hi, cal_hi, read_n,
               power_down_low,
        input  data_o, data_oe, eoc_n
    );
endinterface

// file: hw/padc_pkg.sv
package padc_pkg;
    // Word format
    localparam int          WORD_W       = 16;
    localparam logic [15:0] CODE_NEG_FS  = 16'h8000;
    localparam logic [15:0] CODE_POS_FS  = 16'h7FFF;
    localparam logic [15:0] CODE_MID     = 16'h0000;
    // Differential input bounds before the output clamps
    localparam logic signed [16:0] ANALOG_MIN = 17'sh18000;
    localparam logic signed [16:0] ANALOG_MAX = 17'sh07FFF;
    // Pipeline and timing
    localparam int          PIPE_DEPTH   = 13;
    localparam int          RESET_MIN_CY = 2;
    localparam int          CAL_CYCLES   = 272800;
    localparam int          CAL_W        = 19;
    localparam int          CLK_HZ       = 50000000;
    localparam int          SAMPLE_HZ    = 2500000;
    // Cycles of i_clk per sample clock period, rounded up (slowest legal rate at max speed)
    localparam int          SAMPLE_DIV   = (CLK_HZ + SAMPLE_HZ - 1) / SAMPLE_HZ;
    localparam int          DIV_W        = 8;
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SAMPLE_DIV - 1);
    localparam logic [DIV_W-1:0] DIV_HALF = DIV_W'(SAMPLE_DIV / 2 - 1);
    localparam logic [DIV_W-1:0] DIV_ZERO = 8'h00;
    localparam int          FILL_W       = 4;
    // Converter modes
    typedef enum logic [1:0]
    {
        PADC_RESET = 2'b00,
        PADC_CAL   = 2'b01,
        PADC_RUN   = 2'b10,
        PADC_IDLE  = 2'b11
    } padc_mode_t;
endpackage
